// ### sar_adc_conversion_control.sv
// conversion control of a 12-bit successive approximation converter
// Notes on behaviour
// - start strobe falling edge samples and converts
// - busy rises only after start goes low
// - result port is twelve lines wide
// - straight binary code, step is full scale/4096
// - drivers on only with select and read low
// - lines release when select or read rises
// - tied-low read shows data before busy falls
// - strobe level at conversion end picks mode
// - new start edge during busy restarts conversion
// - acquisition lasts at least 120 ns settling
// - sleep mode strobe pulse during busy restarts
// - low strobe at busy fall enters sleep
// - select high partial sleep, low full sleep
// - strobe rising edge wakes from sleep
// - partial wake holds off starts for 1 us
// - full sleep wake takes 500 us
// - sleeps stop oscillator and comparator, full sleep also turns the reference off
// - sleep type change while asleep is ignored
// - conversion lasts 880 ns start to busy fall
`timescale 1ns/10ps
module sar_adc_conversion_control #(
  parameter int BITS             = sar_adc_pkg::RESULT_BITS,
  parameter int DEPTH            = sar_adc_pkg::FIFO_DEPTH,
  parameter int CONV_CYCLES      = sar_adc_pkg::CONV_CYC,
  parameter int SETTLE_CYCLES    = sar_adc_pkg::SETTLE_CYC,
  parameter int PART_WAKE_CYCLES = sar_adc_pkg::PART_WAKE_CYC,
  parameter int FULL_WAKE_CYCLES = sar_adc_pkg::FULL_WAKE_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // host control pins
  input  wire logic       conversionStartN,
  input  wire logic       sleepTypeSelect,
  input  wire logic       chipSelectN,
  input  wire logic       readN,
  // parallel result port
  output logic [BITS-1:0] dataOut,
  output logic            dataOe,
  output logic            busy,
  // analog front end
  input  wire logic       compareIn,
  output logic [BITS-1:0] dacCode,
  output logic            holdSample,
  // power control
  output logic            oscEnable,
  output logic            comparatorOn,
  output logic            refBufferLowPower,
  output logic            referenceOn
);
  localparam int CW   = $clog2(CONV_CYCLES);
  localparam int SETW = $clog2(SETTLE_CYCLES + 1);
  localparam int WKW  = $clog2(FULL_WAKE_CYCLES + 1);
  localparam int NP   = sar_adc_pkg::PIN_COUNT;
  localparam int LAST = sar_adc_pkg::SYNC_STAGES - 1;

  sar_adc_pkg::conv_state_t state_r;
  sar_adc_pkg::conv_state_t state_nxt;
  logic [NP-1:0]   filt_r;
  logic [NP-1:0]   filt_nxt;
  logic            startPrev_r;
  logic            pending_r;
  logic            pending_nxt;
  logic            outLoaded_r;
  logic            sleepPartial_r;
  logic [CW-1:0]   convCnt_r;
  logic [SETW-1:0] settleCnt_r;
  logic [WKW-1:0]  wakeCnt_r;
  logic [BITS-1:0] outReg_r;
  logic [WKW-1:0]  wakeLen_r;
  logic [BITS-1:0] lastPush_r;
  logic [NP-1:0]   pinsIn;

  stream_if #(.WIDTH(BITS)) resBus ();
  stream_if #(.WIDTH(BITS)) fifoOut ();

  assign pinsIn = {conversionStartN, sleepTypeSelect, chipSelectN, readN};

  // three-stage pin synchronisers, a change counts when stages 2 and 3 agree
  for (genvar i = 0; i < NP; i++) begin : g_sync
    logic [LAST:0] chain_r;
    always_ff @(posedge clk) begin
      // idle levels until the pins settle
      if (rst) begin
        chain_r <= {(LAST + 1){sar_adc_pkg::PIN_RESET[i]}};
      end else begin
        chain_r <= {chain_r[LAST-1:0], pinsIn[i]};
      end
    end
    assign filt_nxt[i] = (chain_r[LAST-1] == chain_r[LAST]) ?
                         chain_r[LAST] : filt_r[i];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filt_r      <= sar_adc_pkg::PIN_RESET;
      startPrev_r <= sar_adc_pkg::PIN_RESET[sar_adc_pkg::PIN_START];
    end else begin
      filt_r      <= filt_nxt;
      startPrev_r <= filt_r[sar_adc_pkg::PIN_START];
    end
  end

  wire logic startLvl   = filt_r[sar_adc_pkg::PIN_START];
  wire logic sleepLvl   = filt_r[sar_adc_pkg::PIN_SLEEP];
  wire logic csLvl      = filt_r[sar_adc_pkg::PIN_CS];
  wire logic rdLvl      = filt_r[sar_adc_pkg::PIN_RD];
  wire logic startFall  = startPrev_r && !startLvl;
  wire logic startRise  = !startPrev_r && startLvl;
  wire logic inAcq      = state_r == sar_adc_pkg::ST_ACQ;
  wire logic inConv     = state_r == sar_adc_pkg::ST_CONV;
  wire logic inSleep    = state_r == sar_adc_pkg::ST_SLEEP;
  wire logic inWake     = state_r == sar_adc_pkg::ST_WAKE;
  wire logic readActive = !csLvl && !rdLvl;

  wire logic acqGo = inAcq && (startFall || pending_r) && settleCnt_r == '0;
  wire logic restart = inConv && startFall;
  wire logic engineStart = acqGo || restart;
  wire logic convEnd = inConv && !startFall && outLoaded_r &&
                       convCnt_r == CW'(CONV_CYCLES - 1);
  wire logic wakeDone = inWake && wakeCnt_r == '0;
  wire logic [WKW-1:0] wakeLoad = sleepPartial_r ?
                                  WKW'(PART_WAKE_CYCLES - 1) :
                                  WKW'(FULL_WAKE_CYCLES - 1);
  // results may refresh while a tied-low read spans busy
  wire logic drainReady = !readActive || inConv;
  wire logic load = fifoOut.valid && drainReady;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sar_adc_pkg::ST_ACQ: begin
        if (acqGo) begin
          state_nxt = sar_adc_pkg::ST_CONV;
        end
      end
      // strobe level at the end picks the mode
      sar_adc_pkg::ST_CONV: begin
        if (convEnd) begin
          state_nxt = startLvl ? sar_adc_pkg::ST_ACQ :
                                 sar_adc_pkg::ST_SLEEP;
        end
      end
      sar_adc_pkg::ST_SLEEP: begin
        if (startRise) begin
          state_nxt = sar_adc_pkg::ST_WAKE;
        end
      end
      sar_adc_pkg::ST_WAKE: begin
        if (wakeDone) begin
          state_nxt = sar_adc_pkg::ST_ACQ;
        end
      end
      default: begin
        state_nxt = sar_adc_pkg::ST_ACQ;
      end
    endcase
  end

  // early start edges wait for the wake interval
  assign pending_nxt = acqGo ? 1'b0 :
                       (startFall && (inAcq || inWake)) ? 1'b1 : pending_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r   <= sar_adc_pkg::ST_ACQ;
      pending_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      pending_r <= pending_nxt;
    end
  end

  // conversion timer restarts with every start
  always_ff @(posedge clk) begin
    if (rst || engineStart) begin
      convCnt_r <= '0;
    end else if (inConv && convCnt_r != CW'(CONV_CYCLES - 1)) begin
      convCnt_r <= convCnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      settleCnt_r <= '0;
    end else if (convEnd) begin
      settleCnt_r <= SETW'(SETTLE_CYCLES);
    end else if (settleCnt_r != '0) begin
      settleCnt_r <= settleCnt_r - 1'b1;
    end
  end

  // wake counter starts with the restarted oscillator
  always_ff @(posedge clk) begin
    if (rst) begin
      wakeCnt_r <= '0;
    end else if (inSleep && startRise) begin
      wakeCnt_r <= wakeLoad;
    end else if (inWake && wakeCnt_r != '0) begin
      wakeCnt_r <= wakeCnt_r - 1'b1;
    end
  end

  // sleep type caught only on entry
  always_ff @(posedge clk) begin
    if (rst) begin
      sleepPartial_r <= 1'b0;
    end else if (convEnd && !startLvl) begin
      sleepPartial_r <= sleepLvl;
    end
  end

  // hold busy until the new result sits in the output register
  always_ff @(posedge clk) begin
    if (rst || engineStart) begin
      outLoaded_r <= 1'b0;
    end else if (load && inConv) begin
      outLoaded_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      outReg_r <= '0;
    end else if (load) begin
      outReg_r <= fifoOut.data;
    end
  end

  sar_approx #(
    .BITS (BITS),
    .STEP (sar_adc_pkg::STEP_CYC)
  ) u_approx (
    .clk       (clk),
    .rst       (rst),
    .start     (engineStart),
    .compareIn (compareIn),
    .dacCode   (dacCode),
    .res       (resBus)
  );

  sync_fifo #(
    .WIDTH (BITS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk (clk),
    .rst (rst),
    .wr  (resBus),
    .rd  (fifoOut)
  );

  assign fifoOut.ready = drainReady;

  // busy only in the conversion state
  assign busy       = inConv;
  assign holdSample = inConv;
  // drive only while select and read are low
  assign dataOe     = readActive;
  assign dataOut    = outReg_r;
  assign oscEnable         = !inSleep;
  assign comparatorOn      = !inSleep;
  assign refBufferLowPower = inSleep && sleepPartial_r;
  assign referenceOn       = !(inSleep && !sleepPartial_r);

  // helper state for the checks below
  always_ff @(posedge clk) begin
    if (rst || !inWake) begin
      wakeLen_r <= '0;
    end else begin
      wakeLen_r <= wakeLen_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lastPush_r <= '0;
    end else if (resBus.valid && resBus.ready) begin
      lastPush_r <= resBus.data;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_busy_after_fall: assert property (
    $rose(busy) |-> $past(startFall || pending_r))
    else $error("busy rose without a start edge");
  a_read_drives: assert property (
    (!chipSelectN && !readN)[*5] |-> dataOe)
    else $error("data not driven during a read");
  a_release_bus: assert property (
    readN[*5] |-> !dataOe)
    else $error("data driven with read high");
  a_data_first: assert property (
    $fell(busy) |-> dataOut == lastPush_r && $stable(dataOut))
    else $error("result not ready before busy fell");
  a_mode_select: assert property (
    $fell(busy) |-> inSleep == !$past(startLvl))
    else $error("wrong mode after conversion");
  a_restart_conv: assert property (
    busy && startFall |=> busy && convCnt_r == '0)
    else $error("start edge did not restart conversion");
  a_settle_time: assert property (
    $fell(busy) ##1 !busy |-> !busy[*8])
    else $error("conversion began inside settling");
  a_sleep_type: assert property (
    $fell(busy) && inSleep |-> sleepPartial_r == $past(sleepLvl))
    else $error("sleep type not taken from select");
  a_wake_on_rise: assert property (
    inSleep && startRise |=> inWake && oscEnable)
    else $error("no wake on rising edge");
  a_partial_wake: assert property (
    $rose(inWake) && sleepPartial_r |-> ##PART_WAKE_CYCLES inAcq)
    else $error("partial wake interval wrong");
  a_full_wake: assert property (
    wakeDone && !sleepPartial_r |->
      wakeLen_r == WKW'(FULL_WAKE_CYCLES - 1))
    else $error("full wake interval wrong");
  a_sleep_power: assert property (
    inSleep |-> !oscEnable && !comparatorOn &&
      referenceOn == sleepPartial_r)
    else $error("sleep power state wrong");
  a_type_frozen: assert property (
    inSleep && $past(inSleep) |-> $stable(sleepPartial_r))
    else $error("sleep type changed while asleep");
  a_conv_length: assert property (
    $fell(busy) |-> $past(convCnt_r) == CW'(CONV_CYCLES - 1))
    else $error("conversion length wrong");

  c_fast_mode: cover property ($fell(busy) && inAcq ##[1:60] $rose(busy));
  c_partial_cycle: cover property ($rose(inWake) && sleepPartial_r);
  c_full_sleep: cover property ($fell(busy) && inSleep && !sleepPartial_r);
  c_restart: cover property (busy && startFall);
endmodule : sar_adc_conversion_control

// ### sar_adc_conversion_control_tb_top.sv
// self-checking bench of the converter control
`timescale 1ns/10ps
module sar_adc_conversion_control_tb_top;
  localparam int BITS   = sar_adc_pkg::RESULT_BITS;
  localparam int CONV   = sar_adc_pkg::CONV_CYC;
  localparam int SETTLE = sar_adc_pkg::SETTLE_CYC;
  localparam int PART   = 200;
  localparam int FULL   = 300;
  // twenty microseconds of wait after a partial wake, in clock cycles
  localparam int LATE   =
    20 * sar_adc_pkg::NS_PER_US / sar_adc_pkg::CLK_PERIOD_NS;

  logic            clk              = 1'b0;
  logic            rst              = 1'b1;
  logic            conversionStartN = 1'b1;
  logic            sleepTypeSelect  = 1'b0;
  logic            chipSelectN      = 1'b1;
  logic            readN            = 1'b1;
  logic [BITS-1:0] vinCode          = '0;
  logic [BITS-1:0] dataOut;
  logic [BITS-1:0] dacCode;
  logic [BITS-1:0] lastOut;
  logic            dataOe;
  logic            busy;
  logic            compareIn;
  logic            holdSample;
  logic            oscEnable;
  logic            comparatorOn;
  logic            refBufferLowPower;
  logic            referenceOn;
  int              n_mismatch       = 0;
  int              compares         = 0;

  always #2.5 clk = ~clk;

  sar_adc_conversion_control #(
    .PART_WAKE_CYCLES(PART),
    .FULL_WAKE_CYCLES(FULL)
  ) sar_adc_conversion_control_i (
    .clk(clk), .rst(rst),
    .conversionStartN(conversionStartN),
    .sleepTypeSelect(sleepTypeSelect),
    .chipSelectN(chipSelectN), .readN(readN),
    .dataOut(dataOut), .dataOe(dataOe), .busy(busy),
    .compareIn(compareIn), .dacCode(dacCode), .holdSample(holdSample),
    .oscEnable(oscEnable), .comparatorOn(comparatorOn),
    .refBufferLowPower(refBufferLowPower), .referenceOn(referenceOn)
  );

  sar_frontend_model sar_frontend_model_i (
    .clk(clk), .vinCode(vinCode), .holdSample(holdSample),
    .dacCode(dacCode), .compareIn(compareIn)
  );

  task automatic summarize;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic chk_val(input logic [BITS-1:0] got,
                         input logic [BITS-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_range(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_range

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic wait_busy(input logic lvl, input int maxc, output int n);
    n = 0;
    while (busy !== lvl && n < maxc) begin
      lastOut = dataOut;
      @(negedge clk);
      n++;
    end
  endtask : wait_busy

  task automatic convert(input logic [BITS-1:0] code, input logic keepLow,
                         output int tRise, output int tHigh);
    vinCode          = code;
    conversionStartN = 1'b0;
    wait_busy(1'b1, 20, tRise);
    if (!keepLow) conversionStartN = 1'b1;
    wait_busy(1'b0, CONV + 20, tHigh);
  endtask : convert

  task automatic rd_check(input logic [BITS-1:0] code);
    chipSelectN = 1'b0;
    readN       = 1'b0;
    cyc(4);
    chk_bit(dataOe, 1'b1);
    chk_val(dataOut, code);
    readN = 1'b1;
    cyc(4);
    chk_bit(dataOe, 1'b0);
    chipSelectN = 1'b1;
  endtask : rd_check

  task automatic t_fast;
    logic [BITS-1:0] codes [7] = '{12'h000, 12'hfff, 12'h800, 12'h7ff,
                                   12'h555, 12'haaa, 12'h001};
    int r;
    int h;
    convert(12'h000, 1'b0, r, h);
    cyc(28);
    foreach (codes[i]) begin
      convert(codes[i], 1'b0, r, h);
      chk_range(r, 2, 6);
      chk_range(h, CONV, CONV);
      chk_bit(oscEnable, 1'b1);
      chk_bit(holdSample, 1'b0);
      cyc(28);
      rd_check(codes[i]);
    end
  endtask : t_fast

  task automatic t_read_port;
    chipSelectN = 1'b0;
    cyc(4);
    chk_bit(dataOe, 1'b0);
    readN = 1'b0;
    cyc(4);
    chk_bit(dataOe, 1'b1);
    chipSelectN = 1'b1;
    cyc(4);
    chk_bit(dataOe, 1'b0);
    chipSelectN = 1'b0;
    cyc(4);
    chk_bit(dataOe, 1'b1);
    readN = 1'b1;
    cyc(4);
    chk_bit(dataOe, 1'b0);
    chipSelectN = 1'b1;
  endtask : t_read_port

  task automatic t_restart;
    int n;
    vinCode          = 12'h321;
    conversionStartN = 1'b0;
    wait_busy(1'b1, 20, n);
    chk_bit(holdSample, 1'b1);
    chk_val(dacCode, 12'h800);
    conversionStartN = 1'b1;
    cyc(40);
    conversionStartN = 1'b0;
    cyc(2);
    conversionStartN = 1'b1;
    wait_busy(1'b0, CONV + 40, n);
    chk_range(n, CONV, CONV + 6);
    cyc(28);
    rd_check(12'h321);
  endtask : t_restart

  task automatic t_settle;
    int r;
    int h;
    convert(12'h0f0, 1'b0, r, h);
    vinCode          = 12'h60c;
    conversionStartN = 1'b0;
    wait_busy(1'b1, 60, r);
    chk_range(r, SETTLE - 2, SETTLE + 6);
    conversionStartN = 1'b1;
    wait_busy(1'b0, CONV + 20, h);
    cyc(28);
    rd_check(12'h60c);
  endtask : t_settle

  task automatic t_tied_low;
    int r;
    int h;
    chipSelectN = 1'b0;
    readN       = 1'b0;
    cyc(4);
    convert(12'h9a5, 1'b0, r, h);
    chk_val(lastOut, 12'h9a5);
    chk_bit(dataOe, 1'b1);
    chipSelectN = 1'b1;
    readN       = 1'b1;
    cyc(28);
  endtask : t_tied_low

  task automatic t_sleep(input logic part, input int wake);
    int r;
    int h;
    sleepTypeSelect = part;
    cyc(6);
    convert(12'h3c7, 1'b1, r, h);
    cyc(2);
    chk_bit(oscEnable, 1'b0);
    chk_bit(comparatorOn, 1'b0);
    chk_bit(refBufferLowPower, part);
    chk_bit(referenceOn, part);
    sleepTypeSelect = ~part;
    cyc(10);
    chk_bit(refBufferLowPower, part);
    chk_bit(referenceOn, part);
    vinCode          = 12'h4b8;
    conversionStartN = 1'b1;
    cyc(2);
    conversionStartN = 1'b0;
    wait_busy(1'b1, wake + 40, r);
    chk_range(r, wake, wake + 8);
    chk_bit(oscEnable, 1'b1);
    conversionStartN = 1'b1;
    wait_busy(1'b0, CONV + 20, h);
    cyc(28);
    rd_check(12'h4b8);
    sleepTypeSelect = 1'b0;
  endtask : t_sleep

  task automatic t_late_wake;
    int n;
    int r;
    int h;
    sleepTypeSelect  = 1'b1;
    cyc(6);
    vinCode          = 12'h5a3;
    conversionStartN = 1'b0;
    wait_busy(1'b1, 20, n);
    cyc(40);
    conversionStartN = 1'b1;
    cyc(2);
    conversionStartN = 1'b0;
    wait_busy(1'b0, CONV + 40, n);
    chk_range(n, CONV, CONV + 6);
    cyc(2);
    chk_bit(oscEnable, 1'b0);
    conversionStartN = 1'b1;
    cyc(LATE);
    convert(12'h0c3, 1'b0, r, h);
    chk_range(r, 2, 6);
    chk_range(h, CONV, CONV);
    cyc(28);
    rd_check(12'h0c3);
    sleepTypeSelect  = 1'b0;
  endtask : t_late_wake

  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end

  initial begin
    cyc(5);
    rst = 1'b0;
    cyc(4);
    t_fast();
    t_read_port();
    t_restart();
    t_settle();
    t_tied_low();
    t_sleep(1'b1, PART);
    t_sleep(1'b0, FULL);
    t_late_wake();
    summarize();
  end
endmodule : sar_adc_conversion_control_tb_top

// ### sar_adc_pkg.sv
// shared constants and types of the converter control
package sar_adc_pkg;
  localparam int RESULT_BITS     = 12;
  localparam int FIFO_DEPTH      = 32;
  localparam int SYNC_STAGES     = 3;
  localparam int CLK_PERIOD_NS   = 5;
  localparam int CONV_TIME_NS    = 880;
  localparam int SETTLE_TIME_NS  = 120;
  localparam int PART_WAKE_US    = 1;
  localparam int FULL_WAKE_US    = 500;
  localparam int NS_PER_US       = 1000;
  localparam int CONV_CYC        = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int SETTLE_CYC      =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PART_WAKE_CYC   =
    (PART_WAKE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FULL_WAKE_CYC   =
    (FULL_WAKE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // one decision per step, one spare step for the hand-off
  localparam int STEP_CYC        = CONV_CYC / (RESULT_BITS + 1);
  localparam int PIN_RD          = 0;
  localparam int PIN_CS          = 1;
  localparam int PIN_SLEEP       = 2;
  localparam int PIN_START       = 3;
  localparam int PIN_COUNT       = 4;
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 4'hb;

  typedef enum logic [1:0] {
    ST_ACQ   = 2'b00,
    ST_CONV  = 2'b01,
    ST_SLEEP = 2'b11,
    ST_WAKE  = 2'b10
  } conv_state_t;
endpackage : sar_adc_pkg

// ### sar_approx.sv
// successive approximation engine, one bit decision per step
`timescale 1ns/10ps
module sar_approx #(
  parameter int BITS = sar_adc_pkg::RESULT_BITS,
  parameter int STEP = sar_adc_pkg::STEP_CYC
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // control and comparator
  input  wire logic  start,
  input  wire logic  compareIn,
  // trial code and finished result
  output logic [BITS-1:0] dacCode,
  stream_if.src      res
);
  localparam int SW = $clog2(STEP);
  localparam int IW = $clog2(BITS);
  logic            active_r;
  logic            valid_r;
  logic [IW-1:0]   bitIdx_r;
  logic [SW-1:0]   stepCnt_r;
  logic [BITS-1:0] code_r;
  logic [BITS-1:0] result_r;
  wire logic            stepEnd = active_r && stepCnt_r == SW'(STEP - 1);
  wire logic            lastBit = bitIdx_r == '0;
  wire logic [BITS-1:0] curBit  = BITS'(1) << bitIdx_r;
  // keep the trial bit while the input is at or above the trial level
  wire logic [BITS-1:0] decided = compareIn ? code_r : (code_r & ~curBit);

  always_ff @(posedge clk) begin
    if (rst) begin
      active_r  <= 1'b0;
      valid_r   <= 1'b0;
      bitIdx_r  <= '0;
      stepCnt_r <= '0;
      code_r    <= '0;
      result_r  <= '0;
    end else if (start) begin
      active_r  <= 1'b1;
      valid_r   <= 1'b0;
      bitIdx_r  <= IW'(BITS - 1);
      stepCnt_r <= '0;
      code_r    <= BITS'(1) << (BITS - 1);
    end else begin
      if (valid_r && res.ready) begin
        valid_r <= 1'b0;
      end
      if (active_r) begin
        stepCnt_r <= stepEnd ? '0 : stepCnt_r + 1'b1;
      end
      if (stepEnd && lastBit) begin
        active_r <= 1'b0;
        valid_r  <= 1'b1;
        result_r <= decided;
        code_r   <= decided;
      end else if (stepEnd) begin
        code_r   <= decided | (curBit >> 1);
        bitIdx_r <= bitIdx_r - 1'b1;
      end
    end
  end

  assign res.valid = valid_r;
  assign res.data  = result_r;
  assign dacCode   = code_r;

  a_result_held: assert property (@(posedge clk) disable iff (rst)
    valid_r && !res.ready && !start |=> valid_r && $stable(result_r))
    else $error("result dropped while stalled");
endmodule : sar_approx

// ### sar_frontend_model.sv
// analog front end stand-in: track/hold and comparator
`timescale 1ns/10ps
module sar_frontend_model #(
  parameter int BITS = sar_adc_pkg::RESULT_BITS
) (
  // clock
  input  wire logic            clk,
  // analog input as an ideal code
  input  wire logic [BITS-1:0] vinCode,
  // converter side
  input  wire logic            holdSample,
  input  wire logic [BITS-1:0] dacCode,
  output logic                 compareIn
);
  logic [BITS-1:0] heldCode_r;

  always_ff @(posedge clk) begin
    if (!holdSample) heldCode_r <= vinCode;
  end

  assign compareIn = (heldCode_r >= dacCode);
endmodule : sar_frontend_model

// ### stream_if.sv
// valid/ready word carrier between the converter's modules
`timescale 1ns/10ps
interface stream_if #(parameter int WIDTH = 12);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// ### sync_fifo.sv
// synchronous word fifo with honest full and empty
`timescale 1ns/10ps
module sync_fifo #(
  parameter int WIDTH = sar_adc_pkg::RESULT_BITS,
  parameter int DEPTH = sar_adc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill and drain sides
  stream_if.snk    wr,
  stream_if.src    rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_r;
  logic [AW:0]      rptr_r;
  wire logic        empty = wptr_r == rptr_r;
  wire logic        full  = (wptr_r[AW] != rptr_r[AW]) &&
                            (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
  wire logic        push  = wr.valid && !full;
  wire logic        pop   = !empty && rd.ready;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rptr_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_r[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      wptr_r <= wptr_r + {{AW{1'b0}}, push};
      rptr_r <= rptr_r + {{AW{1'b0}}, pop};
    end
  end

  a_fifo_fill: assert property (@(posedge clk) disable iff (rst)
    push && !pop |=> !empty)
    else $error("fifo empty after a push");
  c_fifo_full: cover property (@(posedge clk) disable iff (rst) full);
endmodule : sync_fifo
